//--- lit_core_model.sv
// Behavioural core taking deliveries, prompt or slow
`timescale 1ns/1ps
`default_nettype none
module lit_core_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Delivery handshake
    input wire logic deliver_valid,
    input wire logic slow,
    output logic deliver_accept
);
    int w;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deliver_accept <= 1'b0;
            w <= 0;
        end else begin
            deliver_accept <= deliver_valid && !deliver_accept && w >= (slow ? 3 : 0);
            w <= (deliver_valid && !deliver_accept) ? w + 1 : 0;
        end
    end
endmodule
`default_nettype wire

//--- lit_regs.vh
// Register offsets, fields and reset values of the local interrupt and timer unit
`ifndef LIT_REGS_VH
`define LIT_REGS_VH
`define LIT_OFF_TMR_LVT 12'h000
`define LIT_OFF_TMR_INIT 12'h004
`define LIT_OFF_TMR_CUR 12'h008
`define LIT_OFF_LINT_LVT 12'h00c
`define LIT_OFF_DONE 12'h010
`define LIT_OFF_INSVC 12'h014
`define LIT_OFF_IRQ_STAT 12'h018
`define LIT_OFF_IRQ_MASK 12'h01c
`define LIT_OFF_STATUS 12'h020
`define LIT_LVT_MASK_BIT 16
`define LIT_LVT_PERIODIC_BIT 17
`define LIT_LVT_LEGACY_BIT 8
`define LIT_LVT_RESET 32'h00010000
`define LIT_EV_TIMER 0
`define LIT_EV_LINT 1
`define LIT_EV_DELIV 2
`define LIT_EV_W 3
`endif

//--- lit_unit.v
// Local vector table, interval timer and in-service tracking for one core
//
// Function
// - Periodic timer reloads itself on the tick at count one, so the count never reaches zero
// - Timer decrements only on reference ticks
// - Masked table entry never delivers interrupts
// - In-service vector blocks equal or lower priority class, except a legacy-mode LINT entry
// - Done write clears highest in-service bit
// - Legacy interrupt waits for enable, delivered once
// - Each timer expiry sets the timer pending bit; expiries before its offer merge into one interrupt
`timescale 1ns/1ps
`default_nettype none
`include "lit_regs.vh"

module lit_unit (
    // Clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // Asynchronous pins
    input wire ref_clk,
    input wire lint_pin,
    input wire deep_sleep_state,
    // Core side
    input wire core_interrupt_enable_flag,
    output reg deliver_valid,
    output reg [7:0] deliver_vector,
    input wire deliver_accept,
    output wire irq
);

    // ==========================================================
    // Functions
    function [7:0] highest_bit;
        input [255:0] bits;
        integer k;
        begin
            highest_bit = 8'h00;
            for (k = 0; k < 256; k = k + 1) begin
                if (bits[k]) begin
                    highest_bit = k[7:0];
                end
            end
        end
    endfunction

    // Bit positions of the one-hot register select
    localparam SEL_TMR_LVT = 0;
    localparam SEL_TMR_INIT = 1;
    localparam SEL_TMR_CUR = 2;
    localparam SEL_LINT_LVT = 3;
    localparam SEL_DONE = 4;
    localparam SEL_INSVC = 5;
    localparam SEL_IRQ_STAT = 6;
    localparam SEL_IRQ_MASK = 7;
    localparam SEL_STATUS = 8;

    // All zero for a hole or a misaligned address
    function [8:0] reg_sel;
        input [11:0] addr;
        begin
            reg_sel = 9'h000;
            case (addr)
                `LIT_OFF_TMR_LVT: reg_sel[SEL_TMR_LVT] = 1'b1;
                `LIT_OFF_TMR_INIT: reg_sel[SEL_TMR_INIT] = 1'b1;
                `LIT_OFF_TMR_CUR: reg_sel[SEL_TMR_CUR] = 1'b1;
                `LIT_OFF_LINT_LVT: reg_sel[SEL_LINT_LVT] = 1'b1;
                `LIT_OFF_DONE: reg_sel[SEL_DONE] = 1'b1;
                `LIT_OFF_INSVC: reg_sel[SEL_INSVC] = 1'b1;
                `LIT_OFF_IRQ_STAT: reg_sel[SEL_IRQ_STAT] = 1'b1;
                `LIT_OFF_IRQ_MASK: reg_sel[SEL_IRQ_MASK] = 1'b1;
                `LIT_OFF_STATUS: reg_sel[SEL_STATUS] = 1'b1;
                default: reg_sel = 9'h000;
            endcase
        end
    endfunction

    // ==========================================================
    // Pin synchronisers
    // Two flops per pin; logic only ever reads the second stage
    localparam PIN_REF = 0;
    localparam PIN_LINT = 1;
    localparam PIN_SLEEP = 2;
    localparam PIN_IE = 3;
    localparam NUM_PINS = 4;
    wire [NUM_PINS-1:0] pin_raw;
    wire [NUM_PINS-1:0] pin_sync;
    assign pin_raw[PIN_REF] = ref_clk;
    assign pin_raw[PIN_LINT] = lint_pin;
    assign pin_raw[PIN_SLEEP] = deep_sleep_state;
    assign pin_raw[PIN_IE] = core_interrupt_enable_flag;
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g = g + 1) begin : g_sync
            reg stage1;
            reg stage2;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end else if (clk_en) begin
                    stage1 <= pin_raw[g];
                    stage2 <= stage1;
                end
            end
            assign pin_sync[g] = stage2;
        end
    endgenerate
    reg ref_q;
    wire ref_tick = pin_sync[PIN_REF] & ~ref_q;
    reg lint_q;
    wire lint_rise = pin_sync[PIN_LINT] & ~lint_q;
    wire sleeping = pin_sync[PIN_SLEEP];
    wire ie_flag = pin_sync[PIN_IE];

    // ==========================================================
    // APB decode
    wire [8:0] sel = reg_sel(paddr);
    wire wr = psel & penable & pwrite;
    // Read data is captured in the setup cycle so it stands for the whole access
    wire rd_setup = psel & ~penable & ~pwrite;
    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    wire mapped = |sel;
    assign pslverr = psel & penable & ~mapped;
    wire [8:0] wsel = wr ? sel : 9'h000;

    reg [31:0] tmr_lvt, lint_lvt, tmr_init, tmr_cur;
    reg [`LIT_EV_W-1:0] irq_stat, irq_mask;
    reg [255:0] in_service;
    reg tmr_run, tmr_pend, lint_pend;
    wire [7:0] top_isr = highest_bit(in_service);
    wire any_isr = |in_service;
    wire done_wr = wsel[SEL_DONE];
    wire init_wr = wsel[SEL_TMR_INIT];

    // ==========================================================
    // Timer
    wire expire = tmr_run && ref_tick && tmr_cur == 32'h00000001;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_q <= 1'b0;
            tmr_cur <= 32'h00000000;
            tmr_run <= 1'b0;
        end else if (clk_en) begin
            ref_q <= pin_sync[PIN_REF];
            if (init_wr) begin
                tmr_cur <= pwdata;
                tmr_run <= (pwdata != 32'h00000000);
            end else if (tmr_run && ref_tick) begin
                if (tmr_cur == 32'h00000001) begin
                    if (tmr_lvt[`LIT_LVT_PERIODIC_BIT]) begin
                        // Reload on the tick itself, so no tick is skipped
                        tmr_cur <= tmr_init;
                    end else begin
                        tmr_cur <= 32'h00000000;
                        tmr_run <= 1'b0;
                    end
                end else begin
                    tmr_cur <= tmr_cur - 32'h00000001;
                end
            end
        end
    end

    // ==========================================================
    // Pending, delivery and in-service
    wire tmr_masked = tmr_lvt[`LIT_LVT_MASK_BIT];
    wire lint_masked = lint_lvt[`LIT_LVT_MASK_BIT];
    wire lint_legacy = lint_lvt[`LIT_LVT_LEGACY_BIT];
    wire [7:0] tmr_vec = tmr_lvt[7:0];
    wire [7:0] lint_vec = lint_lvt[7:0];
    // Priority class is the upper vector nibble
    wire tmr_ok = tmr_pend && !tmr_masked && !sleeping
        && (!any_isr || tmr_vec[7:4] > top_isr[7:4]);
    wire lint_ok = lint_pend && !lint_masked && !sleeping
        && (lint_legacy ? ie_flag : (!any_isr || lint_vec[7:4] > top_isr[7:4]));
    // Delivery handshake states
    localparam [1:0] DLV_IDLE = 2'b01;
    localparam [1:0] DLV_OFFER = 2'b10;
    reg [1:0] dlv_state;
    // Fixed at offer time, so a table rewrite while the core is slow cannot change it
    reg deliv_sets_isr;
    wire taken = deliver_valid & deliver_accept;
    reg [255:0] next_in_service;
    always @* begin
        next_in_service = in_service;
        if (done_wr && any_isr) begin
            next_in_service[top_isr] = 1'b0;
        end
        if (taken && deliv_sets_isr) begin
            next_in_service[deliver_vector] = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lint_q <= 1'b0;
            tmr_pend <= 1'b0;
            lint_pend <= 1'b0;
            dlv_state <= DLV_IDLE;
            deliver_valid <= 1'b0;
            deliver_vector <= 8'h00;
            deliv_sets_isr <= 1'b0;
            in_service <= 256'h0;
        end else if (clk_en) begin
            lint_q <= pin_sync[PIN_LINT];
            in_service <= next_in_service;
            case (dlv_state)
                DLV_IDLE: begin
                    if (tmr_ok) begin
                        dlv_state <= DLV_OFFER;
                        deliver_valid <= 1'b1;
                        deliver_vector <= tmr_vec;
                        deliv_sets_isr <= 1'b1;
                        tmr_pend <= 1'b0;
                    end else if (lint_ok) begin
                        dlv_state <= DLV_OFFER;
                        deliver_valid <= 1'b1;
                        deliver_vector <= lint_vec;
                        // Legacy mode is closed by the core, not by a done write
                        deliv_sets_isr <= !lint_legacy;
                        lint_pend <= 1'b0;
                    end
                end
                DLV_OFFER: begin
                    // Vector stands until the core takes it
                    if (deliver_accept) begin
                        dlv_state <= DLV_IDLE;
                        deliver_valid <= 1'b0;
                    end
                end
                default: begin
                    dlv_state <= DLV_IDLE;
                    deliver_valid <= 1'b0;
                end
            endcase
            // Set wins over the clear of the same cycle
            if (expire) begin
                tmr_pend <= 1'b1;
            end
            if (lint_rise) begin
                lint_pend <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Registers and interrupt status
    wire [`LIT_EV_W-1:0] ev = {taken, lint_rise, expire};
    reg [`LIT_EV_W-1:0] next_irq_stat;
    always @* begin
        next_irq_stat = irq_stat;
        if (wsel[SEL_IRQ_STAT]) begin
            next_irq_stat = next_irq_stat & ~pwdata[`LIT_EV_W-1:0];
        end
        // Set wins: an event in the clearing cycle survives
        next_irq_stat = next_irq_stat | ev;
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_lvt <= `LIT_LVT_RESET;
            lint_lvt <= `LIT_LVT_RESET;
            tmr_init <= 32'h00000000;
            irq_stat <= {`LIT_EV_W{1'b0}};
            irq_mask <= {`LIT_EV_W{1'b0}};
        end else if (clk_en) begin
            if (wsel[SEL_TMR_LVT]) begin
                tmr_lvt <= pwdata;
            end
            if (wsel[SEL_LINT_LVT]) begin
                lint_lvt <= pwdata;
            end
            if (init_wr) begin
                tmr_init <= pwdata;
            end
            if (wsel[SEL_IRQ_MASK]) begin
                irq_mask <= pwdata[`LIT_EV_W-1:0];
            end
            irq_stat <= next_irq_stat;
        end
    end
    assign irq = |(irq_stat & irq_mask);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (clk_en && rd_setup) begin
            case (paddr)
                `LIT_OFF_TMR_LVT: prdata <= tmr_lvt;
                `LIT_OFF_TMR_INIT: prdata <= tmr_init;
                `LIT_OFF_TMR_CUR: prdata <= tmr_cur;
                `LIT_OFF_LINT_LVT: prdata <= lint_lvt;
                `LIT_OFF_INSVC: prdata <= {23'h0, any_isr, top_isr};
                `LIT_OFF_IRQ_STAT: prdata <= {29'h0, irq_stat};
                `LIT_OFF_IRQ_MASK: prdata <= {29'h0, irq_mask};
                `LIT_OFF_STATUS: prdata <= {28'h0, tmr_run, lint_pend, tmr_pend, deliver_valid};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

endmodule
`default_nettype wire

//--- lit_unit_properties.sv
// Port timing checker for the local interrupt unit
`timescale 1ns/1ps
`default_nettype none
module lit_unit_properties (
    // Clock and control
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Core side
    input wire logic deliver_valid,
    input wire logic [7:0] deliver_vector,
    input wire logic deliver_accept,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire bad = paddr > 12'h020 || paddr[1:0] != 2'h0;
    property p_ready; acc |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("no pready");
    property p_bad; acc && bad |-> pslverr; endproperty
    a_bad: assert property (p_bad) else $error("no error");
    property p_good; acc && !bad |-> !pslverr; endproperty
    a_good: assert property (p_good) else $error("false error");
    property p_bad_rd; acc && !pwrite && bad |-> prdata == 32'h0; endproperty
    a_bad_rd: assert property (p_bad_rd) else $error("bad read data");
    property p_stand; acc && !pwrite && clk_en |=> $stable(prdata); endproperty
    a_stand: assert property (p_stand) else $error("read data moved");
    property p_mask; acc && pwrite && clk_en && paddr == 12'h01c && pwdata == 0 |=> !irq;
    endproperty
    a_mask: assert property (p_mask) else $error("masked irq");
    property p_hold; deliver_valid && !deliver_accept |=> deliver_valid && $stable(deliver_vector);
    endproperty
    a_hold: assert property (p_hold) else $error("delivery dropped");
    property p_frz; !clk_en |=> $stable(deliver_valid); endproperty
    a_frz: assert property (p_frz) else $error("not frozen");
    c_dlv: cover property (deliver_valid && deliver_accept);
    c_err: cover property (acc && pslverr);
    c_irq: cover property (irq);
endmodule
bind lit_unit lit_unit_properties i_chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .deliver_valid, .deliver_vector,
    .deliver_accept, .irq);
`default_nettype wire

//--- local_interrupt_timer_lvt_test.sv
// Self-checking bench of the local interrupt and timer unit
`timescale 1ns/1ps
`default_nettype none
module local_interrupt_timer_lvt_test;
    logic pclk, presetn, clk_en, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, q;
    logic ref_clk, lint_pin, sleep, ien, slow;
    wire pready, pslverr, deliver_valid, deliver_accept, irq;
    wire [31:0] prdata;
    wire [7:0] deliver_vector;
    int bad_count = 0, n_compared = 0, cyc = 0, n;
    logic [7:0] got_q[$], exp_q[$];
    always #25 pclk = ~pclk;
    lit_unit i_lit_unit (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .ref_clk, .lint_pin, .deep_sleep_state(sleep),
        .core_interrupt_enable_flag(ien), .deliver_valid, .deliver_vector, .deliver_accept, .irq);
    lit_core_model i_lit_core_model (.pclk, .presetn, .deliver_valid, .slow, .deliver_accept);
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (deliver_valid && deliver_accept) got_q.push_back(deliver_vector);
        if (cyc == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    task chk(input string s, input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 0;
        penable <= 0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk("read", q, e);
    endtask
    task tick(input int k);
        repeat (k) begin
            ref_clk <= 1;
            repeat (3) @(posedge pclk);
            ref_clk <= 0;
            repeat (3) @(posedge pclk);
        end
    endtask
    task pulse();
        lint_pin <= 1;
        repeat (4) @(posedge pclk);
        lint_pin <= 0;
    endtask
    // Model queue against what the core took
    task match();
        repeat (40) @(posedge pclk);
        chk("count", got_q.size(), exp_q.size());
        while (got_q.size() && exp_q.size()) chk("vector", got_q.pop_front(), exp_q.pop_front());
        got_q = {};
        exp_q = {};
    endtask
    task stop_test();
        $display("compared %0d wrong %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        presetn <= 1'b0;
        clk_en <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h00000000;
        ref_clk <= 1'b0;
        lint_pin <= 1'b0;
        sleep <= 1'b0;
        ien <= 1'b0;
        slow <= 1'b0;
        n = $urandom(42);
        n = 2 + $urandom % 3;
        repeat (10) @(posedge pclk);
        presetn <= 1;
        rd(12'h000, 32'h00010000);
        rd(12'h00c, 32'h00010000);
        rd(12'h040, 0);
        rd(12'h002, 0);
        apb(1, 12'h01c, 7);
        // Periodic, second expiry held until a done write clears the vector
        apb(1, 12'h000, 32'h20050);
        apb(1, 12'h004, n);
        tick(n - 1);
        match();
        tick(1);
        exp_q.push_back(8'h50);
        match();
        rd(12'h014, 32'h150);
        tick(n);
        match();
        apb(1, 12'h010, 0);
        exp_q.push_back(8'h50);
        match();
        apb(1, 12'h010, 0);
        rd(12'h014, 0);
        tick(n - 1);
        match();
        tick(1);
        exp_q.push_back(8'h50);
        match();
        apb(1, 12'h004, 0);
        apb(1, 12'h010, 0);
        @(negedge pclk);
        chk("irq", irq, 1);
        apb(1, 12'h01c, 0);
        apb(1, 12'h018, 7);
        apb(1, 12'h01c, 7);
        @(negedge pclk);
        chk("irq", irq, 0);
        // One-shot with sleep at count one
        slow <= 1;
        apb(1, 12'h000, 32'h60);
        apb(1, 12'h004, 2);
        tick(1);
        sleep <= 1;
        tick(1);
        match();
        sleep <= 0;
        exp_q.push_back(8'h60);
        match();
        tick(3);
        match();
        rd(12'h008, 0);
        apb(1, 12'h010, 0);
        apb(1, 12'h00c, 32'h10070);
        pulse();
        apb(1, 12'h00c, 32'h10071);
        match();
        apb(1, 12'h00c, 32'h71);
        exp_q.push_back(8'h71);
        match();
        apb(1, 12'h010, 0);
        apb(1, 12'h00c, 32'h172);
        pulse();
        match();
        ien <= 1;
        exp_q.push_back(8'h72);
        match();
        clk_en <= 0;
        repeat (3) @(posedge pclk);
        clk_en <= 1;
        stop_test();
    end
endmodule
`default_nettype wire
